// file: bench/cpu_interrupt_priority_serial_bits_tb.sv
`timescale 1ns/10ps
module cpu_interrupt_priority_serial_bits_tb;
  import irq_pkg::*;
  logic clk, resetn, cyc, stb, we, hi, lo, edg, serial_in, hold, ack, trap, gen;
  logic serial_out, hsync, half, ack_strobe;
  logic [1:0] raise;
  logic [3:0] adr;
  logic [31:0] wdat, rdat, dat_o;
  logic [7:0] mrd;
  core_cmd_s cmd;
  take_s take;
  int n_errors, checks_done;
  irq_priority dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .trap_pin(trap), .restart_edge_pin(edg), .restart_hi_pin(hi), .restart_lo_pin(lo),
    .general_interrupt_request(gen), .serial_input_line(serial_in), .bus_hold_request(hold),
    .core_cmd(cmd), .take(take), .interrupt_acknowledge_strobe(ack_strobe),
    .mask_read_data(mrd), .serial_output_line(serial_out), .bus_hold_sync(hsync),
    .internal_clock_out(half));
  irq_sources src (.clk(clk), .resetn(resetn), .raise(raise), .take(take), .trap_pin(trap),
    .general_interrupt_request(gen));
  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      chk("ack", ack, 1);
      complete_run();
    end
  endtask : wb
  function automatic core_cmd_s mk(input logic [4:0] f, input logic [7:0] a);
    return core_cmd_s'({f, a});
  endfunction : mk
  task automatic pulse(input core_cmd_s c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= '0;
  endtask : pulse
  task automatic mread(output logic [7:0] v);
    pulse(mk(5'h01, 8'h00));
    #1 v = mrd;
  endtask : mread
  task automatic kick(input logic [1:0] r);
    @(posedge clk);
    raise <= r;
    @(posedge clk);
    raise <= 2'h0;
    repeat (4) @(posedge clk);
  endtask : kick
  task automatic edge_pulse;
    @(posedge clk);
    edg <= 1'b1;
    repeat (2) @(posedge clk);
    edg <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : edge_pulse
  // Boundary pulse, then expect a push and its branch (general acknowledge for the general source), or nothing
  task automatic service(input logic want, input logic [15:0] vec, input logic gsrc);
    logic seen;
    seen = 1'b0;
    pulse(mk(5'h10, 8'h00));
    for (int i = 0; i < 4 && !seen; i++) begin
      @(negedge clk);
      seen = (take.push_pc === 1'b1);
    end
    chk("accept", seen, want);
    if (want && !seen) complete_run();
    if (seen && !gsrc) chk("vector", take.vector, vec);
    if (seen) @(negedge clk);
    if (seen && gsrc) chk("gen ack", {take.ack_general, ack_strobe}, 2'h3);
    if (seen && !gsrc) chk("branch", take.branch, 1);
  endtask : service
  // Main sequence
  initial begin
    logic [7:0] v;
    logic b;
    resetn = 1'b0;
    {cyc, stb, we, hi, lo, edg, serial_in, hold, raise, adr, wdat} = '0;
    cmd = '0;
    b = 1'($urandom(16717));
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    mread(v);
    chk("reset ie masks", v[3:0], 4'h7);
    wb(1'b0, STATUS_OFFSET, 32'h0);
    chk("status masks", rdat[3:0], 4'h7);
    wb(1'b0, 4'h8, 32'h0);
    chk("unmapped", rdat, 32'h0);
    wb(1'b1, CTRL_OFFSET, 32'h1);
    wb(1'b0, CTRL_OFFSET, 32'h0);
    chk("ctrl", rdat, 32'h1);
    wb(1'b1, CTRL_OFFSET, 32'h0);
    $display("test reset and registers done");
    for (int k = 0; k < 4; k++) begin
      b = 1'($urandom);
      serial_in <= b;
      hold <= b;
      pulse(mk(5'h02, {~b, 7'h40}));
      repeat (3) @(posedge clk);
      mread(v);
      chk("serial out", serial_out, !b);
      chk("serial in", v[7], b);
      chk("masks kept", v[2:0], 3'h7);
      chk("hold sync", hsync, b);
      @(negedge clk) b = half;
      @(negedge clk) chk("half clock", half, !b);
    end
    $display("test serial bits done");
    edge_pulse();
    mread(v);
    chk("edge masked", v[6], 1);
    pulse(mk(5'h02, 8'h10));
    mread(v);
    chk("edge clear", v[6], 0);
    $display("test edge latch done");
    pulse(mk(5'h02, 8'h08));
    hi <= 1'b1;
    repeat (4) @(posedge clk);
    service(1'b0, VEC_NONE, 1'b0);
    pulse(mk(5'h02, 8'h0a));
    pulse(mk(5'h08, 8'h00));
    service(1'b0, VEC_NONE, 1'b0);
    pulse(mk(5'h02, 8'h08));
    service(1'b1, VEC_HI, 1'b0);
    hi <= 1'b0;
    mread(v);
    chk("ie cleared", v[3], 0);
    $display("test masking done");
    hi <= 1'b1;
    lo <= 1'b1;
    kick(2'h2);
    edge_pulse();
    service(1'b0, VEC_NONE, 1'b0);
    pulse(mk(5'h08, 8'h00));
    service(1'b1, VEC_EDGE, 1'b0);
    mread(v);
    chk("edge serviced", v[6], 0);
    chk("ie off", v[3], 0);
    pulse(mk(5'h08, 8'h00));
    service(1'b1, VEC_HI, 1'b0);
    hi <= 1'b0;
    pulse(mk(5'h08, 8'h00));
    service(1'b1, VEC_LO, 1'b0);
    lo <= 1'b0;
    pulse(mk(5'h08, 8'h00));
    service(1'b1, VEC_NONE, 1'b1);
    pulse(mk(5'h08, 8'h00));
    service(1'b0, VEC_NONE, 1'b0);
    $display("test priority done");
    pulse(mk(5'h02, 8'h0f));
    wb(1'b1, CTRL_OFFSET, 32'h1);
    kick(2'h1);
    service(1'b0, VEC_NONE, 1'b0);
    wb(1'b1, CTRL_OFFSET, 32'h0);
    service(1'b1, VEC_TRAP, 1'b0);
    mread(v);
    chk("saved ie", v[3], 1);
    mread(v);
    chk("current ie", v[3], 0);
    $display("test trap done");
    edge_pulse();
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    mread(v);
    chk("reset edge masks", {v[6], v[3:0]}, 5'h07);
    $display("test mid reset done");
    complete_run();
  end
endmodule : cpu_interrupt_priority_serial_bits_tb

// file: bench/irq_sources.sv
`timescale 1ns/10ps
module irq_sources (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [1:0] raise,
  input wire irq_pkg::take_s take,
  output logic trap_pin,
  output logic general_interrupt_request
);
  import irq_pkg::*;
  // Trap source holds its level until the trap restart is pushed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trap_pin <= 1'b0;
    end else if (raise[0]) begin
      trap_pin <= 1'b1;
    end else if (take.push_pc && take.vector == VEC_TRAP) begin
      trap_pin <= 1'b0;
    end
  end
  // General source holds its level until acknowledged
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      general_interrupt_request <= 1'b0;
    end else if (raise[1]) begin
      general_interrupt_request <= 1'b1;
    end else if (take.ack_general) begin
      general_interrupt_request <= 1'b0;
    end
  end
endmodule : irq_sources

// file: design/irq_pkg.sv
package irq_pkg;

  // Wishbone register offsets (byte addresses)
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic CTRL_RESET = 1'b0;
  localparam int CTRL_FREEZE_BIT = 0;

  // Synchronised input positions
  localparam int PIN_TRAP = 0;
  localparam int PIN_EDGE = 1;
  localparam int PIN_HI = 2;
  localparam int PIN_LO = 3;
  localparam int PIN_GEN = 4;
  localparam int PIN_SERIAL_IN = 5;
  localparam int PIN_HOLD = 6;
  localparam int PIN_COUNT = 7;

  // Mask-set accumulator layout
  localparam int SET_SERIAL_DATA_BIT = 7;
  localparam int SET_SOE_BIT = 6;
  localparam int SET_EDGE_CLR_BIT = 4;
  localparam int SET_MSE_BIT = 3;

  // Mask-read result layout
  localparam int READ_SERIAL_IN_BIT = 7;
  localparam int READ_PEND_LSB = 4;
  localparam int READ_IE_BIT = 3;

  // Values after reset
  localparam logic [2:0] MASK_RESET = 3'h7;
  localparam logic SERIAL_OUT_RESET = 1'b0;

  // Restart addresses
  localparam logic [15:0] VEC_TRAP = 16'h0024;
  localparam logic [15:0] VEC_EDGE = 16'h003c;
  localparam logic [15:0] VEC_HI = 16'h0034;
  localparam logic [15:0] VEC_LO = 16'h002c;
  localparam logic [15:0] VEC_NONE = 16'h0000;

  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_TRAP = 3'b001,
    SRC_EDGE = 3'b010,
    SRC_HI = 3'b011,
    SRC_LO = 3'b100,
    SRC_GEN = 3'b101
  } src_e;

  typedef enum logic [1:0] {
    SVC_IDLE = 2'b00,
    SVC_PUSH = 2'b01,
    SVC_BRANCH = 2'b10
  } svc_e;

  typedef struct packed {
    logic instr_boundary;
    logic enable_interrupts_instruction;
    logic di;
    logic mask_set;
    logic mask_read;
    logic [7:0] acc;
  } core_cmd_s;

  typedef struct packed {
    logic push_pc;
    logic branch;
    logic ack_general;
    logic [15:0] vector;
  } take_s;

endpackage : irq_pkg

// file: design/irq_priority.sv
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
module irq_priority (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic trap_pin,
  input wire logic restart_edge_pin,
  input wire logic restart_hi_pin,
  input wire logic restart_lo_pin,
  input wire logic general_interrupt_request,
  input wire logic serial_input_line,
  input wire logic bus_hold_request,
  input wire irq_pkg::core_cmd_s core_cmd,
  output irq_pkg::take_s take,
  output logic interrupt_acknowledge_strobe,
  output logic [7:0] mask_read_data,
  output logic serial_output_line,
  output logic bus_hold_sync,
  output logic internal_clock_out
);
  import irq_pkg::*;

  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] sync1;
  logic [PIN_COUNT-1:0] sync2;
  logic trap_d;
  logic edge_d;
  logic trap_rise;
  logic edge_rise;
  logic trap_req;
  logic edge_req;
  logic [2:0] masks;
  logic ie;
  logic saved_ie;
  logic saved_valid;
  logic freeze;
  logic [4:0] req;
  src_e next_src;
  src_e cur_src;
  svc_e state;
  logic accept;
  logic wb_hit;
  logic [15:0] vector_q;

  // Priority pick among pending requests
  function automatic src_e pick(input logic [4:0] r);
    if (r[0]) begin
      pick = SRC_TRAP;
    end else if (r[1]) begin
      pick = SRC_EDGE;
    end else if (r[2]) begin
      pick = SRC_HI;
    end else if (r[3]) begin
      pick = SRC_LO;
    end else if (r[4]) begin
      pick = SRC_GEN;
    end else begin
      pick = SRC_NONE;
    end
  endfunction : pick

  // Restart address of a source
  function automatic logic [15:0] vector_of(input src_e s);
    case (s)
      SRC_TRAP: vector_of = VEC_TRAP;
      SRC_EDGE: vector_of = VEC_EDGE;
      SRC_HI: vector_of = VEC_HI;
      SRC_LO: vector_of = VEC_LO;
      default: vector_of = VEC_NONE;
    endcase
  endfunction : vector_of

  assign pin_raw = {bus_hold_request, serial_input_line, general_interrupt_request,
                    restart_lo_pin, restart_hi_pin, restart_edge_pin, trap_pin};

  // Two-stage synchronisers on every pin
  generate
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          sync1[i] <= 1'b0;
          sync2[i] <= 1'b0;
        end else begin
          sync1[i] <= pin_raw[i];
          sync2[i] <= sync1[i];
        end
      end
    end
  endgenerate

  assign bus_hold_sync = sync2[PIN_HOLD];

  // Internal clock at half rate
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      internal_clock_out <= 1'b0;
    end else begin
      internal_clock_out <= ~internal_clock_out;
    end
  end

  // Delayed copies for edge detection
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trap_d <= 1'b0;
      edge_d <= 1'b0;
    end else begin
      trap_d <= sync2[PIN_TRAP];
      edge_d <= sync2[PIN_EDGE];
    end
  end

  assign trap_rise = sync2[PIN_TRAP] & ~trap_d;
  assign edge_rise = sync2[PIN_EDGE] & ~edge_d;

  // Request vector, bit 0 highest
  assign req[0] = trap_req;
  assign req[1] = edge_req & ~masks[2] & ie;
  assign req[2] = sync2[PIN_HI] & ~masks[1] & ie;
  assign req[3] = sync2[PIN_LO] & ~masks[0] & ie;
  assign req[4] = sync2[PIN_GEN] & ie;
  assign next_src = pick(req);
  // No memory of the routine in service enters the pick
  assign accept = (state == SVC_IDLE) && core_cmd.instr_boundary &&
                  (next_src != SRC_NONE) && !freeze;

  // Nonmaskable request: edge arms it, low level drops it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trap_req <= 1'b0;
    end else if (trap_rise) begin
      trap_req <= 1'b1;
    end else if (!sync2[PIN_TRAP] || (accept && next_src == SRC_TRAP)) begin
      trap_req <= 1'b0;
    end
  end

  // Latched edge restart flag; a new edge wins over any clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      edge_req <= 1'b0;
    end else if (edge_rise) begin
      edge_req <= 1'b1;
    end else if (accept && next_src == SRC_EDGE) begin
      edge_req <= 1'b0;
    end else if (core_cmd.mask_set && core_cmd.acc[SET_EDGE_CLR_BIT]) begin
      edge_req <= 1'b0;
    end
  end

  // Restart masks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      masks <= MASK_RESET;
    end else if (core_cmd.mask_set && core_cmd.acc[SET_MSE_BIT]) begin
      masks <= core_cmd.acc[2:0];
    end
  end

  // Serial output bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serial_output_line <= SERIAL_OUT_RESET;
    end else if (core_cmd.mask_set && core_cmd.acc[SET_SOE_BIT]) begin
      serial_output_line <= core_cmd.acc[SET_SERIAL_DATA_BIT];
    end
  end

  // Global enable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ie <= 1'b0;
    end else if (accept) begin
      ie <= 1'b0;
    end else if (core_cmd.enable_interrupts_instruction) begin
      ie <= 1'b1;
    end else if (core_cmd.di) begin
      ie <= 1'b0;
    end
  end

  // Enable saved by a nonmaskable service
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      saved_ie <= 1'b0;
      saved_valid <= 1'b0;
    end else if (accept && next_src == SRC_TRAP) begin
      saved_ie <= ie;
      saved_valid <= 1'b1;
    end else if (core_cmd.mask_read) begin
      saved_valid <= 1'b0;
    end
  end

  // Mask-read result
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mask_read_data <= 8'h00;
    end else if (core_cmd.mask_read) begin
      mask_read_data[READ_SERIAL_IN_BIT] <= sync2[PIN_SERIAL_IN];
      mask_read_data[READ_PEND_LSB+2:READ_PEND_LSB] <=
          {edge_req, sync2[PIN_HI], sync2[PIN_LO]};
      mask_read_data[READ_IE_BIT] <= saved_valid ? saved_ie : ie;
      mask_read_data[2:0] <= masks;
    end
  end

  // Service sequence: push, then branch
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= SVC_IDLE;
      cur_src <= SRC_NONE;
      vector_q <= VEC_NONE;
    end else begin
      case (state)
        SVC_IDLE: begin
          if (accept) begin
            state <= SVC_PUSH;
            cur_src <= next_src;
            vector_q <= vector_of(next_src);
          end
        end
        SVC_PUSH: state <= SVC_BRANCH;
        SVC_BRANCH: state <= SVC_IDLE;
        default: state <= SVC_IDLE;
      endcase
    end
  end

  // Strobes towards the core
  assign take.vector = vector_q;
  assign take.push_pc = (state == SVC_PUSH);
  assign take.branch = (state == SVC_BRANCH) && (cur_src != SRC_GEN);
  assign take.ack_general = (state == SVC_BRANCH) && (cur_src == SRC_GEN);
  assign interrupt_acknowledge_strobe = take.ack_general;

  // Wishbone slave, one wait cycle
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  // Control register write, taken at the edge that sees ack
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      freeze <= CTRL_RESET;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
                 wb_adr_i == CTRL_OFFSET && wb_sel_i[0]) begin
      freeze <= wb_dat_i[CTRL_FREEZE_BIT];
    end
  end

  // Register read data; unmapped reads zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_hit && !wb_we_i) begin
      case (wb_adr_i)
        CTRL_OFFSET: wb_dat_o <= {31'h0000_0000, freeze};
        STATUS_OFFSET: wb_dat_o <= {19'h0_0000, state, saved_valid,
                                    serial_output_line, sync2[PIN_GEN],
                                    sync2[PIN_LO], sync2[PIN_HI], edge_req,
                                    trap_req, ie, masks};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  property p_trap_vec;
    @(posedge clk) disable iff (!resetn)
    accept && next_src == SRC_TRAP |=> take.vector == VEC_TRAP && take.push_pc;
  endproperty
  a_trap_vec: assert property (p_trap_vec)
    else $error("trap vector or push missing");

  property p_edge_latch;
    @(posedge clk) disable iff (!resetn)
    edge_rise |=> edge_req;
  endproperty
  a_edge_latch: assert property (p_edge_latch)
    else $error("edge flag not set by pulse");

  property p_push_then_branch;
    @(posedge clk) disable iff (!resetn)
    take.push_pc |=> (take.branch || take.ack_general) ##1 !take.push_pc;
  endproperty
  a_push_then_branch: assert property (p_push_then_branch)
    else $error("branch did not follow push");

  property p_enable_cleared;
    @(posedge clk) disable iff (!resetn)
    accept |=> !ie [*2];
  endproperty
  a_enable_cleared: assert property (p_enable_cleared)
    else $error("enable still set after service");

  property p_trap_unmasked;
    @(posedge clk) disable iff (!resetn)
    trap_req && state == SVC_IDLE && core_cmd.instr_boundary && !freeze
      |=> state == SVC_PUSH && cur_src == SRC_TRAP;
  endproperty
  a_trap_unmasked: assert property (p_trap_unmasked)
    else $error("trap not taken");

  property p_mask_gate;
    @(posedge clk) disable iff (!resetn)
    accept && next_src == SRC_HI |-> ie && !masks[1];
  endproperty
  a_mask_gate: assert property (p_mask_gate)
    else $error("masked restart taken");

  property p_edge_cleared;
    @(posedge clk) disable iff (!resetn)
    accept && next_src == SRC_EDGE && !edge_rise |=> !edge_req;
  endproperty
  a_edge_cleared: assert property (p_edge_cleared)
    else $error("edge flag kept after service");

  property p_trap_rearm;
    @(posedge clk) disable iff (!resetn)
    trap_req && !sync2[PIN_TRAP] |=> !trap_req;
  endproperty
  a_trap_rearm: assert property (p_trap_rearm)
    else $error("trap held without level");

  property p_saved_read;
    @(posedge clk) disable iff (!resetn)
    core_cmd.mask_read && saved_valid
      |=> mask_read_data[READ_IE_BIT] == $past(saved_ie) && !saved_valid;
  endproperty
  a_saved_read: assert property (p_saved_read)
    else $error("saved enable not returned");

  property p_order;
    @(posedge clk) disable iff (!resetn)
    accept && req[1] && !req[0] |-> next_src == SRC_EDGE;
  endproperty
  a_order: assert property (p_order)
    else $error("priority order broken");

  property p_mask_source;
    @(posedge clk) disable iff (!resetn)
    !$stable(masks) |-> $past(core_cmd.mask_set);
  endproperty
  a_mask_source: assert property (p_mask_source)
    else $error("masks changed without mask-set");

  property p_serial_out;
    @(posedge clk) disable iff (!resetn)
    core_cmd.mask_set && core_cmd.acc[SET_SOE_BIT]
      |=> serial_output_line == $past(core_cmd.acc[SET_SERIAL_DATA_BIT]);
  endproperty
  a_serial_out: assert property (p_serial_out)
    else $error("serial output not driven");

endmodule : irq_priority
